// ### shared/ata_burst_pkg.sv
/*
  Constants, cycle counts and carrier types for the ATA burst sequencer.
  Assumes clk_sys at 10 MHz; all cable timing is rounded to whole system cycles.
*/
// How it works
// - multiword: drive may keep request high; host resumes by reasserting acknowledge
// - host suspends multiword by negating acknowledge and resumes by reasserting it
// - sender average two-edge period at least 240, 160, 120 ns per mode
// - sender strobe edges at least 114, 75, 55 ns apart per mode
// - sender holds data valid 70, 48, 34 ns before the strobe edge
// - sender keeps data stable at least 6 ns after its strobe edge
// - recipient samples data on each strobe edge with 15, 10, 7 ns setup
// - host changes stop and ready 20 to 70 ns after asserting acknowledge; the code changes them one 100 ns cycle after
// - ready dropped within strobe-to-ready window: at most one more word sent
// - ready dropped late: recipient still accepts up to two more words
// - sender stops strobing 75, 60, 50 ns after seeing ready negated
// - recipient waits 160, 125, 100 ns after dropping ready before stop
// - sender waits 50 ns after its last strobe edge before stop or request drop
// - host holds other control lines 20 ns around each acknowledge edge
// - minimum interlocks wait at least 20 ns after the other agent's signal
// - bounded interlocks answered within 150 ns; unlimited ones never time out; the code asserts stop 300 ns after request drops only in ST_U_IN
// - burst meanings of strobe lines hold only while request and acknowledge both active
package ata_burst_pkg;

  localparam int CLK_PERIOD_NS = 100;

  // least time: round up, never below one cycle
  function automatic int cyc_up(input int ns);
    return (ns <= CLK_PERIOD_NS) ? 1 : (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  endfunction

  localparam int T2CYC_NS  [3] = '{240, 160, 120};
  localparam int TCYC_NS   [3] = '{114, 75, 55};
  localparam int TDVS_NS   [3] = '{70, 48, 34};
  localparam int TRP_NS    [3] = '{160, 125, 100};
  localparam int TSS_NS        = 50;
  localparam int TACK_NS       = 20;
  localparam int TENV_MIN_NS   = 20;
  localparam int TMLI_NS       = 20;
  localparam int MW_ACT_NS     = 215;
  localparam int MW_REC_NS     = 215;

  localparam int CNT_W = 4;
  typedef logic [CNT_W-1:0] cnt_t;

  function automatic int max2(input int a, input int b);
    return (a > b) ? a : b;
  endfunction

  // cycles from one strobe edge to the next, covering average period, edge gap and setup
  localparam cnt_t GAP_CYC [3] = '{
    cnt_t'(cyc_up(max2(max2(T2CYC_NS[0] / 2 + T2CYC_NS[0] % 2, TCYC_NS[0]), TDVS_NS[0]))),
    cnt_t'(cyc_up(max2(max2(T2CYC_NS[1] / 2 + T2CYC_NS[1] % 2, TCYC_NS[1]), TDVS_NS[1]))),
    cnt_t'(cyc_up(max2(max2(T2CYC_NS[2] / 2 + T2CYC_NS[2] % 2, TCYC_NS[2]), TDVS_NS[2])))};
  localparam cnt_t RP_CYC [3] = '{
    cnt_t'(cyc_up(TRP_NS[0])), cnt_t'(cyc_up(TRP_NS[1])), cnt_t'(cyc_up(TRP_NS[2]))};
  localparam cnt_t SS_CYC     = cnt_t'(cyc_up(TSS_NS));
  localparam cnt_t ACK_CYC    = cnt_t'(cyc_up(TACK_NS));
  localparam cnt_t ENV_CYC    = cnt_t'(cyc_up(TENV_MIN_NS));
  localparam cnt_t MLI_CYC    = cnt_t'(cyc_up(TMLI_NS));
  localparam cnt_t MW_ACT_CYC = cnt_t'(cyc_up(MW_ACT_NS));
  localparam cnt_t MW_REC_CYC = cnt_t'(cyc_up(MW_REC_NS));

  localparam int FIFO_AW   = 4;
  localparam int FIFO_ROOM = 1;

  typedef enum logic [3:0] {
    ST_IDLE     = 4'h0,
    ST_MW_WAIT  = 4'h1,
    ST_MW_SETUP = 4'h2,
    ST_MW_ACT   = 4'h3,
    ST_MW_REC   = 4'h4,
    ST_U_REQ    = 4'h5,
    ST_U_ENV    = 4'h6,
    ST_U_IN     = 4'h7,
    ST_U_PAUSE  = 4'h8,
    ST_U_OWAIT  = 4'h9,
    ST_U_OSETUP = 4'hA,
    ST_U_SS     = 4'hB,
    ST_U_DROP   = 4'hC,
    ST_ACK_OFF  = 4'hD,
    ST_RELEASE  = 4'hE
  } state_e;

  typedef struct packed {
    logic ack_n;
    logic stop_n;
    logic rd_n;
  } host_ctl_s;

  typedef struct packed {
    logic       dir_in;
    logic       udma;
    logic [1:0] mode;
  } xfer_cfg_s;

  localparam host_ctl_s CTL_IDLE = '{ack_n: 1'b1, stop_n: 1'b1, rd_n: 1'b1};

endpackage

// ### verilog/ata_burst_sequencer.sv
/*
  Host-side burst sequencer for one ATA channel: multiword DMA with suspend and
  resume, UltraDMA modes 0 to 2 data-in and data-out bursts.
  Assumes the cable pins are resolved by the surrounding pad logic from the
  output enables, and that link_clk runs free and fast enough to oversample the
  drive's strobe.
*/
`timescale 1ns/1ps

module ata_burst_sequencer (
  input  wire logic                     clk_sys,
  input  wire logic                     sys_rst,
  input  wire logic                     link_clk,
  input  wire logic                     xfer_start,
  input  wire logic                     xfer_dir_in,
  input  wire logic                     xfer_udma,
  input  wire logic [1:0]               xfer_mode,
  input  wire logic                     xfer_stop,
  input  wire logic                     mw_suspend,
  input  wire logic [15:0]              out_word,
  input  wire logic                     out_valid,
  output logic                          out_ready,
  output logic [15:0]                   in_word,
  output logic                          in_valid,
  input  wire logic                     in_ready,
  output logic                          busy,
  input  wire logic                     drive_dma_request,
  input  wire logic                     drive_ready_line,
  output logic                          host_dma_acknowledge_n,
  output logic                          host_write_strobe_n,
  output logic                          host_read_strobe_n,
  input  wire logic [15:0]              cable_data_in,
  output logic [15:0]                   cable_data_out,
  output logic                          cable_data_oe_n
);
  import ata_burst_pkg::*;

  // ---------------- link domain: data-in strobe capture ----------------
  logic              lrst_q1, lrst_q2, lact_q1, lact_q2;
  logic              lstb_q1, lstb_q2, lstb_q3;
  logic [15:0]       ldat_q1, ldat_q2;
  logic [15:0]       fifo_mem [1 << FIFO_AW];
  logic [FIFO_AW:0]  wbin, wgray, next_wbin;
  logic [FIFO_AW:0]  rgray, rgray_l1, rgray_l2;
  logic              lfull, lwrite;
  logic              burst_in_act;

  always_ff @(posedge link_clk) begin
    lrst_q1 <= sys_rst;
    lrst_q2 <= lrst_q1;
    lact_q1 <= burst_in_act;
    lact_q2 <= lact_q1;
    lstb_q1 <= drive_ready_line;
    lstb_q2 <= lstb_q1;
    lstb_q3 <= lstb_q2;
    ldat_q1 <= cable_data_in;
    ldat_q2 <= ldat_q1;
    rgray_l1 <= rgray;
    rgray_l2 <= rgray_l1;
  end

  // data rides two flops alongside the strobe, so each edge takes the word it qualified
  assign lfull  = (wgray == {~rgray_l2[FIFO_AW:FIFO_AW-1], rgray_l2[FIFO_AW-2:0]});
  assign lwrite = lact_q2 && (lstb_q2 ^ lstb_q3) && !lfull;
  always_comb next_wbin = lwrite ? wbin + 1'b1 : wbin;

  always_ff @(posedge link_clk) begin
    if (lrst_q2) begin
      wbin  <= '0;
      wgray <= '0;
    end else begin
      wbin  <= next_wbin;
      wgray <= next_wbin ^ (next_wbin >> 1);
    end
    if (lwrite) begin
      fifo_mem[wbin[FIFO_AW-1:0]] <= ldat_q2;
    end
  end

  // ---------------- system domain ----------------
  logic [FIFO_AW:0]  rbin, next_rbin, wgray_s1, wgray_s2, wbin_s, fill;
  logic              req_q1, req_s, rdy_q1, rdy_s;
  logic [15:0]       dat_q1, dat_s;
  state_e            state, next_state;
  cnt_t              cnt, next_cnt;
  host_ctl_s         ctl, next_ctl;
  xfer_cfg_s         cfg, next_cfg;
  logic [15:0]       next_dout, next_in_word;
  logic              next_doe_n, next_in_valid, next_act, pop, mw_cap;
  logic [1:0]        midx;

  always_ff @(posedge clk_sys) begin
    req_q1   <= drive_dma_request;
    req_s    <= req_q1;
    rdy_q1   <= drive_ready_line;
    rdy_s    <= rdy_q1;
    dat_q1   <= cable_data_in;
    dat_s    <= dat_q1;
    wgray_s1 <= wgray;
    wgray_s2 <= wgray_s1;
  end

  // gray to binary: each bit is the parity of the bits at and above it
  for (genvar gi = 0; gi <= FIFO_AW; gi++) begin : g_wgray_bin
    assign wbin_s[gi] = ^(wgray_s2 >> gi);
  end

  assign fill      = wbin_s - rbin;
  assign pop       = (fill != '0) && (!in_valid || in_ready);
  assign next_rbin = pop ? rbin + 1'b1 : rbin;
  assign midx      = (cfg.mode == 2'h3) ? 2'h2 : cfg.mode;

  always_comb begin
    next_in_word  = in_word;
    next_in_valid = in_valid && !in_ready;
    if (pop) begin
      next_in_word  = fifo_mem[rbin[FIFO_AW-1:0]];
      next_in_valid = 1'b1;
    end else if (mw_cap) begin
      next_in_word  = dat_s;
      next_in_valid = 1'b1;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      rbin     <= '0;
      rgray    <= '0;
      in_word  <= '0;
      in_valid <= 1'b0;
    end else begin
      rbin     <= next_rbin;
      rgray    <= next_rbin ^ (next_rbin >> 1);
      in_word  <= next_in_word;
      in_valid <= next_in_valid;
    end
  end

  // ---------------- burst sequencer ----------------
  always_comb begin
    next_state = state;
    next_cnt   = (cnt != '0) ? cnt - 1'b1 : cnt;
    next_ctl   = ctl;
    next_cfg   = cfg;
    next_dout  = cable_data_out;
    next_doe_n = cable_data_oe_n;
    next_act   = burst_in_act;
    out_ready  = 1'b0;
    mw_cap     = 1'b0;
    case (state)
      ST_IDLE: begin
        next_ctl   = CTL_IDLE;
        next_doe_n = 1'b1;
        if (xfer_start) begin
          next_cfg   = '{dir_in: xfer_dir_in, udma: xfer_udma, mode: xfer_mode};
          next_state = xfer_udma ? ST_U_REQ : ST_MW_WAIT;
        end
      end
      // multiword: suspended or waiting for the drive, acknowledge negated
      ST_MW_WAIT: begin
        if (xfer_stop) begin
          next_state = ST_IDLE;
        end else if (req_s && !mw_suspend) begin
          next_ctl.ack_n = 1'b0;
          next_cnt       = ACK_CYC;
          next_state     = ST_MW_SETUP;
        end
      end
      ST_MW_SETUP: begin
        if (cnt == '0) begin
          if (xfer_stop || mw_suspend) begin
            next_cnt   = ACK_CYC;
            next_state = ST_ACK_OFF;
          end else if (req_s && (cfg.dir_in ? !in_valid : out_valid)) begin
            if (cfg.dir_in) begin
              next_ctl.rd_n = 1'b0;
            end else begin
              next_ctl.stop_n = 1'b0;
              next_dout       = out_word;
              next_doe_n      = 1'b0;
              out_ready       = 1'b1;
            end
            next_cnt   = MW_ACT_CYC;
            next_state = ST_MW_ACT;
          end
          // request low with acknowledge held: the drive paused, keep waiting
        end
      end
      ST_MW_ACT: begin
        if (cnt == '0) begin
          mw_cap          = cfg.dir_in;
          next_ctl.rd_n   = 1'b1;
          next_ctl.stop_n = 1'b1;
          next_cnt        = MW_REC_CYC;
          next_state      = ST_MW_REC;
        end
      end
      ST_MW_REC: begin
        if (cnt == '0) begin
          next_doe_n = 1'b1;
          next_state = ST_MW_SETUP;
        end
      end
      // ultra: no timeout on the drive's request
      ST_U_REQ: begin
        if (xfer_stop) begin
          next_state = ST_IDLE;
        end else if (req_s) begin
          next_ctl.ack_n = 1'b0;
          next_cnt       = ENV_CYC - 1'b1;
          next_state     = ST_U_ENV;
        end
      end
      ST_U_ENV: begin
        if (cnt == '0) begin
          next_ctl.stop_n = 1'b0;
          if (cfg.dir_in) begin
            next_ctl.rd_n = 1'b0;
            next_act      = 1'b1;
            next_state    = ST_U_IN;
          end else begin
            next_state = ST_U_OWAIT;
          end
        end
      end
      // data-in: ready held only while the buffer keeps room for late words
      ST_U_IN: begin
        if (!req_s) begin
          next_ctl.stop_n = 1'b1;
          next_cnt        = ACK_CYC;
          next_state      = ST_ACK_OFF;
        end else if (xfer_stop || fill > FIFO_ROOM[FIFO_AW:0]) begin
          next_ctl.rd_n = 1'b1;
          next_cnt      = RP_CYC[midx];
          next_state    = ST_U_PAUSE;
        end
      end
      ST_U_PAUSE: begin
        if (!req_s) begin
          next_cnt   = ACK_CYC;
          next_state = ST_ACK_OFF;
        end else if (cnt == '0) begin
          if (xfer_stop) begin
            next_ctl.stop_n = 1'b1;
            next_state      = ST_U_DROP;
          end else if (fill <= FIFO_ROOM[FIFO_AW:0]) begin
            next_ctl.rd_n = 1'b0;
            next_state    = ST_U_IN;
          end
        end
      end
      // data-out: drive's ready line is active low in this phase
      ST_U_OWAIT: begin
        if (!req_s) begin
          next_cnt   = ACK_CYC;
          next_state = ST_ACK_OFF;
        end else if (xfer_stop) begin
          next_cnt   = SS_CYC;
          next_state = ST_U_SS;
        end else if (!rdy_s && out_valid) begin
          next_dout  = out_word;
          next_doe_n = 1'b0;
          out_ready  = 1'b1;
          next_cnt   = GAP_CYC[midx] - 1'b1;
          next_state = ST_U_OSETUP;
        end
      end
      ST_U_OSETUP: begin
        if (!req_s) begin
          next_cnt   = ACK_CYC;
          next_state = ST_ACK_OFF;
        end else if (cnt == '0 && !rdy_s) begin
          next_ctl.rd_n = ~ctl.rd_n;
          next_state    = ST_U_OWAIT;
        end
      end
      ST_U_SS: begin
        if (cnt == '0) begin
          next_ctl.stop_n = 1'b1;
          next_state      = ST_U_DROP;
        end
      end
      ST_U_DROP: begin
        if (!req_s) begin
          next_cnt   = MLI_CYC;
          next_state = ST_ACK_OFF;
        end
      end
      ST_ACK_OFF: begin
        next_act = 1'b0;
        if (cnt == '0) begin
          next_ctl.ack_n = 1'b1;
          next_cnt       = ACK_CYC;
          next_state     = ST_RELEASE;
        end
      end
      ST_RELEASE: begin
        if (cnt == '0) begin
          next_ctl   = CTL_IDLE;
          next_doe_n = 1'b1;
          next_state = (!cfg.udma && !xfer_stop) ? ST_MW_WAIT : ST_IDLE;
        end
      end
      default: begin
        next_state = ST_IDLE;
        next_ctl   = CTL_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      state           <= ST_IDLE;
      cnt             <= '0;
      ctl             <= CTL_IDLE;
      cfg             <= '0;
      cable_data_out  <= '0;
      cable_data_oe_n <= 1'b1;
      burst_in_act    <= 1'b0;
    end else begin
      state           <= next_state;
      cnt             <= next_cnt;
      ctl             <= next_ctl;
      cfg             <= next_cfg;
      cable_data_out  <= next_dout;
      cable_data_oe_n <= next_doe_n;
      burst_in_act    <= next_act;
    end
  end

  // in burst phases the write strobe line carries stop, asserted while this port is high
  assign host_dma_acknowledge_n = ctl.ack_n;
  assign host_write_strobe_n    = ctl.stop_n;
  assign host_read_strobe_n     = ctl.rd_n;
  assign busy                   = (state != ST_IDLE);

endmodule // ata_burst_sequencer

// ### verification/ata_burst_assertions.sv
/* Port checker for the burst sequencer, bound to its top module.
   Assumes the transfer settings stay steady while a transfer runs. */
`timescale 1ns/1ps
module ata_burst_checker (
  input wire logic        clk_sys,
  input wire logic        sys_rst,
  input wire logic        xfer_udma,
  input wire logic [1:0]  xfer_mode,
  input wire logic        in_ready,
  input wire logic        in_valid,
  input wire logic [15:0] in_word,
  input wire logic        busy,
  input wire logic        drive_ready_line,
  input wire logic        host_dma_acknowledge_n,
  input wire logic        host_write_strobe_n,
  input wire logic        host_read_strobe_n,
  input wire logic [15:0] cable_data_out,
  input wire logic        cable_data_oe_n
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (sys_rst);
  wire logic uin  = !host_dma_acknowledge_n && xfer_udma && cable_data_oe_n;
  wire logic uout = !host_dma_acknowledge_n && xfer_udma && !cable_data_oe_n;

  a_ack_edge_quiet: assert property ($changed(host_dma_acknowledge_n) |->
    $stable(host_write_strobe_n) && $stable(host_read_strobe_n)) else $error("ack edge moved");
  a_stop_after_ack: assert property ($fell(host_dma_acknowledge_n) && xfer_udma |=>
    !host_write_strobe_n) else $error("stop late after ack");
  a_idle_lines: assert property (!busy ##1 !busy |-> host_dma_acknowledge_n &&
    cable_data_oe_n && host_write_strobe_n && host_read_strobe_n) else $error("idle lines");
  a_pause_before_stop: assert property (uin && $rose(host_read_strobe_n) |->
    !host_write_strobe_n ##1 (xfer_mode[1] || !host_write_strobe_n)) else $error("early stop");
  a_ready_stops_strobe: assert property ((uout && drive_ready_line) [*5] |->
    $stable(host_read_strobe_n)) else $error("strobe after ready off");
  a_strobe_spacing: assert property (uout && $changed(host_read_strobe_n) |->
    $stable(cable_data_out) ##1 $stable(host_read_strobe_n))
    else $error("strobe spacing");
  a_mw_strobe_len: assert property (!xfer_udma && $fell(host_read_strobe_n) |->
    !host_read_strobe_n [*3]) else $error("short strobe");
  a_in_word_held: assert property (in_valid && !in_ready |=>
    in_valid && $stable(in_word)) else $error("word lost");
endmodule  // ata_burst_checker

bind ata_burst_sequencer ata_burst_checker u_ata_burst_checker (.clk_sys, .sys_rst,
  .xfer_udma, .xfer_mode, .in_ready, .in_valid, .in_word, .busy, .drive_ready_line,
  .host_dma_acknowledge_n, .host_write_strobe_n, .host_read_strobe_n, .cable_data_out,
  .cable_data_oe_n);

// ### verification/ata_drive_model.sv
/* Behavioural disk drive on the cable side of the burst sequencer.
   Assumes the bench sets the transfer fields before the host starts. */
`timescale 1ns/1ps
module ata_drive_model (
  input  wire logic        clk_sys,
  input  wire logic        want_req,
  input  wire logic        dir_in,
  input  wire logic        udma,
  input  wire logic        ready_en,
  input  wire logic [7:0]  words,
  input  wire logic        ack_n,
  input  wire logic        stop_line,
  input  wire logic        hrd,
  input  wire logic [15:0] host_data,
  input  wire logic        host_oe_n,
  output logic             req = 1'b0,
  output logic             rdy_line = 1'b1,
  output logic [15:0]      data = 16'h0,
  output logic [7:0]       cnt = 8'h0,
  output logic [7:0]       bad = 8'h0
);
  logic live = 1'b0, ph = 1'b0, rd_q = 1'b1, wr_q = 1'b1;
  logic take;
  always @(posedge clk_sys) begin
    rd_q <= hrd;
    wr_q <= stop_line;
    live <= !ack_n && (live || (udma && !stop_line));
    // drop on host stop, during the last multiword strobe, or when told
    req <= want_req && !(live && stop_line) &&
           (udma || cnt + 8'(!ack_n && !(hrd && stop_line)) < words);
    take = udma ? (!dir_in && hrd != rd_q && !host_oe_n) : (dir_in ? hrd && !rd_q : stop_line && !wr_q);
    if (ack_n) begin
      ph <= 1'b0;
      rdy_line <= 1'b1;
      data <= ~data;
    end else if (udma && dir_in) begin
      // word goes out a cycle ahead, so the first strobe can follow stop at once
      if (!ph) begin
        ph <= 1'b1;
        data <= 16'hA500 + 16'(cnt);
      end else if (!stop_line && !hrd && cnt < words) begin
        ph <= 1'b0;
        rdy_line <= !rdy_line;
        cnt <= cnt + 8'h1;
      end
    end else begin
      data <= (udma || !dir_in) ? ~data : 16'hA500 + 16'(cnt);
      if (udma) rdy_line <= !ready_en;
      if (take) cnt <= cnt + 8'h1;
      if (take && !dir_in && host_data !== 16'h5A00 + 16'(cnt)) bad <= bad + 8'h1;
    end
    if (!want_req) cnt <= 8'h0;
  end
endmodule  // ata_drive_model

// ### verification/tb_ata_burst_sequencer.sv
/* Bench for the burst sequencer: a table of transfers, then a mid-burst reset.
   Assumes the drive model and the bound port checker. */
`timescale 1ns/1ps
module tb_ata_burst_sequencer;
  logic        clk_sys = 0, link_clk = 0, sys_rst = 1, xfer_start = 0, xfer_dir_in = 0;
  logic        xfer_udma = 0, xfer_stop = 0, mw_suspend = 0, out_valid = 0, in_ready = 0;
  logic [1:0]  xfer_mode = 0;
  logic [15:0] out_word = 0, in_word, cable_data_in, cable_data_out;
  logic        out_ready, in_valid, busy, drive_dma_request, drive_ready_line;
  logic        host_dma_acknowledge_n, host_write_strobe_n, host_read_strobe_n, cable_data_oe_n;
  logic        p_req = 0, p_ready = 1;
  logic [7:0]  p_words = 0, cnt, bad;
  int          error_cnt = 0, cmp_count = 0;
  typedef struct packed {logic din; logic ud; logic [1:0] md; logic [7:0] n, stall, sus;} row_s;
  // sus: multiword suspend, or drive pause and abort in UltraDMA, after that many words
  row_s rows [10] = '{'{1,1,0,6,0,0}, '{1,1,1,6,0,0}, '{1,1,2,8,40,0}, '{1,1,3,4,0,0},
    '{0,1,0,6,0,0}, '{0,1,1,6,0,0}, '{0,1,2,6,30,0}, '{1,0,0,6,0,2}, '{0,0,0,3,0,0},
    '{0,1,1,20,0,3}};

  initial begin
    forever #50 clk_sys = ~clk_sys;
  end
  initial begin
    #1.3;
    forever #3 link_clk = ~link_clk;
  end

  ata_burst_sequencer u_ata_burst_sequencer (.clk_sys, .sys_rst, .link_clk, .xfer_start,
    .xfer_dir_in, .xfer_udma, .xfer_mode, .xfer_stop, .mw_suspend, .out_word, .out_valid,
    .out_ready, .in_word, .in_valid, .in_ready, .busy, .drive_dma_request, .drive_ready_line,
    .host_dma_acknowledge_n, .host_write_strobe_n, .host_read_strobe_n, .cable_data_in,
    .cable_data_out, .cable_data_oe_n);
  ata_drive_model u_ata_drive_model (.clk_sys, .want_req(p_req), .dir_in(xfer_dir_in),
    .udma(xfer_udma), .ready_en(p_ready), .words(p_words), .ack_n(host_dma_acknowledge_n),
    .stop_line(host_write_strobe_n), .hrd(host_read_strobe_n), .host_data(cable_data_out),
    .host_oe_n(cable_data_oe_n), .req(drive_dma_request), .rdy_line(drive_ready_line),
    .data(cable_data_in), .cnt, .bad);

  task automatic chk(input logic [15:0] act, input logic [15:0] exp);
    cmp_count++;
    if (act !== exp) begin
      error_cnt++;
      $display("ERROR t=%0t got %h expected %h", $time, act, exp);
    end
  endtask

  task automatic final_report();
    $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  task automatic wait_sig(ref logic s, input logic v, input int lim);
    int k;
    k = 0;
    while (s !== v && k < lim) begin
      @(negedge clk_sys);
      k++;
    end
    chk(s, v);
  endtask

  task automatic suspend_check();
    mw_suspend = 1;
    wait_sig(host_dma_acknowledge_n, 1'b1, 30);
    repeat (10) @(negedge clk_sys);
    chk(host_dma_acknowledge_n, 1'b1);
    mw_suspend = 0;
    wait_sig(host_dma_acknowledge_n, 1'b0, 30);
  endtask

  task automatic drive_abort();
    logic [7:0] c0;
    logic [7:0] c1;
    c0 = cnt;
    p_ready = 0;
    repeat (5) @(negedge clk_sys);
    c1 = cnt;
    p_req = 0;
    wait_sig(busy, 1'b0, 30);
    chk(16'(c1 - c0 <= 8'h2), 16'h1);
  endtask

  task automatic run(input row_s r);
    int t, got, nx;
    logic sd;
    t = 0;
    got = 0;
    nx = 0;
    sd = 0;
    xfer_dir_in = r.din;
    xfer_udma = r.ud;
    xfer_mode = r.md;
    p_words = r.n;
    p_ready = (r.stall == 0);
    p_req = 1;
    xfer_start = 1;
    @(negedge clk_sys);
    xfer_start = 0;
    while (got < r.n && t < 2000) begin
      t++;
      in_ready = (t > r.stall);
      if (t == r.stall && !r.din) chk(cnt, 16'h0);
      p_ready = (t >= r.stall);
      out_valid = !r.din && nx < r.n;
      out_word = 16'h5A00 + 16'(nx);
      #1;
      if (in_valid === 1'b1 && in_ready) begin
        chk(in_word, 16'hA500 + 16'(got));
        got++;
      end
      if (out_ready === 1'b1 && out_valid) nx++;
      if (!r.din) got = cnt;
      if (r.sus != 0 && got == r.sus && !sd) begin
        sd = 1;
        if (r.ud) begin
          drive_abort();
          got = r.n;
        end else suspend_check();
      end
      @(negedge clk_sys);
    end
    out_valid = 0;
    chk(16'(got), 16'(r.n));
    chk(bad, 16'h0);
    xfer_stop = 1;
    wait_sig(busy, 1'b0, 60);
    xfer_stop = 0;
    p_req = 0;
    @(negedge clk_sys);
    $display("transfer dir_in=%0d udma=%0d mode=%0d words=%0d done", r.din, r.ud, r.md, r.n);
  endtask

  initial begin
    repeat (20000) @(posedge clk_sys);
    error_cnt++;
    final_report();
  end

  initial begin
    repeat (4) @(negedge clk_sys);
    sys_rst = 0;
    chk({busy, in_valid, host_dma_acknowledge_n, host_write_strobe_n, host_read_strobe_n,
         cable_data_oe_n}, 16'h0F);
    foreach (rows[i]) run(rows[i]);
    xfer_dir_in = 1;
    p_words = 30;
    p_req = 1;
    xfer_start = 1;
    @(negedge clk_sys);
    xfer_start = 0;
    repeat (8) @(negedge clk_sys);
    sys_rst = 1;
    repeat (4) @(negedge clk_sys);
    sys_rst = 0;
    p_req = 0;
    chk({busy, in_valid, host_dma_acknowledge_n, host_write_strobe_n, host_read_strobe_n,
         cable_data_oe_n}, 16'h0F);
    repeat (2) @(negedge clk_sys);
    chk({busy, in_valid, host_dma_acknowledge_n, host_write_strobe_n, host_read_strobe_n,
         cable_data_oe_n}, 16'h0F);
    $display("reset in mid burst done");
    final_report();
  end
endmodule  // tb_ata_burst_sequencer
